// ### dtb_pkg.sv
`default_nettype none
package dtb_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned AW = 16;
  localparam int unsigned DW = 16;
  localparam int unsigned PW = 15;

  // Register byte offsets
  localparam logic [AW-1:0] CTRL_OFS    = 16'hE8AC;
  localparam logic [AW-1:0] CMP_ACT_OFS = 16'hE8B4;
  localparam logic [AW-1:0] CMP_SHD_OFS = 16'hE8B6;
  localparam logic [AW-1:0] CMD_OFS     = 16'hE8A6;
  localparam logic [AW-1:0] SSHOT_OFS   = 16'hE8AE;
  localparam logic [AW-1:0] MPER_OFS    = 16'hE8C0;
  localparam logic [AW-1:0] APER_OFS    = 16'hE8C2;
  localparam logic [AW-1:0] MCNT_OFS    = 16'hE8C4;
  localparam logic [AW-1:0] ACNT_OFS    = 16'hE8C6;

  // Control register fields
  localparam int unsigned MAIN_SEL_LSB = 0;
  localparam int unsigned MAIN_PRE_BIT = 3;
  localparam int unsigned MAIN_RUN_BIT = 4;
  localparam int unsigned MAIN_REQ_BIT = 5;
  localparam int unsigned MAIN_DIR_BIT = 6;
  localparam int unsigned MAIN_CTM_BIT = 7;
  localparam int unsigned AUX_SEL_LSB  = 8;
  localparam int unsigned AUX_PRE_BIT  = 11;
  localparam int unsigned AUX_RUN_BIT  = 12;
  localparam int unsigned AUX_REQ_BIT  = 13;

  // Command register bits, write-only
  localparam int unsigned MAIN_CLR_BIT = 0;
  localparam int unsigned MAIN_SET_BIT = 1;
  localparam int unsigned MAIN_STR_BIT = 6;
  localparam int unsigned MAIN_STD_BIT = 7;
  localparam int unsigned AUX_CLR_BIT  = 8;
  localparam int unsigned AUX_SET_BIT  = 9;
  localparam int unsigned AUX_STR_BIT  = 14;
  localparam int unsigned AUX_STD_BIT  = 15;

  // Single-shot register bits
  localparam int unsigned MAIN_SS_BIT = 0;
  localparam int unsigned AUX_SS_BIT  = 1;

  localparam logic [DW-1:0] ZERO16    = 16'h0000;
  localparam logic [DW-1:0] ONE16     = 16'h0001;
  localparam logic [PW-1:0] PRE_ZERO  = 15'h0000;
  localparam logic [PW-1:0] PRE_ONE   = 15'h0001;
  localparam logic [PW-1:0] PRE_ALL   = 15'h7FFF;
  localparam logic [3:0]    PRE256_SH = 4'h8;

  typedef struct packed {
    logic       pre;
    logic [2:0] sel;
  } dtb_cfg_type;

  localparam dtb_cfg_type CFG_RST = 4'h0;
endpackage
`default_nettype wire

// ### dtb_timer_ctrl.sv
// The implementer's own choice: the plain strobed port.
`default_nettype none
// How it works
// - Active aux compare value feeds the equality check; only hardware changes it
// - Each aux shadow transfer copies shadow compare value into active register
// - Aux run flag gates counting; software set/clear, single-shot clears it
// - Main run flag gates counting; software set/clear, single-shot clears it
// - Simultaneous set and clear requests on a run flag leave it unchanged
// - Prescale enable bit adds a divide-by-256 stage to that timer's clock
// - Three-bit clock select per timer, main bits 2:0, aux bits 10:8
// - Clock select and prescale writes are ignored while that timer runs
// - Main mode bit: 0 edge-aligned counting, 1 center-aligned up/down
// - Read-only direction bit shows main count direction, 1 means down
// - Each timer has a read-only shadow transfer pending flag
// - Pending flag clears by itself when the shadow transfer happens
// - Aux transfer occurs on wrap to zero after period match, or while stopped
// - Writing 1 to run set starts, run clear stops; writing 0 does nothing
// - Active compare is read-only, shadow compare is read-write
module dtb_timer_ctrl (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [dtb_pkg::AW-1:0] reg_addr,
  input  wire logic [dtb_pkg::DW-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [dtb_pkg::DW-1:0] reg_rdata,
  output logic      [dtb_pkg::DW-1:0] main_count,
  output logic      [dtb_pkg::DW-1:0] aux_count,
  output logic                       aux_compare_match,
  output logic                       aux_shadow_transfer_pulse
);

  function automatic logic dtb_hit(input logic [dtb_pkg::AW-1:0] a,
                                   input logic [dtb_pkg::AW-1:0] ofs,
                                   input logic                  stb);
    dtb_hit = stb && (a == ofs);
  endfunction

  // Low ones mask of the prescaler counter for the selected ratio
  function automatic logic [dtb_pkg::PW-1:0] dtb_div_mask(
      input dtb_pkg::dtb_cfg_type c);
    logic [3:0] sh;
    sh = {1'b0, c.sel} + (c.pre ? dtb_pkg::PRE256_SH : 4'h0);
    dtb_div_mask = ~(dtb_pkg::PRE_ALL << sh);
  endfunction

  dtb_pkg::dtb_cfg_type   main_cfg, aux_cfg;
  logic                   main_alignment_mode, main_count_direction;
  logic                   main_run_flag, aux_run_flag;
  logic                   main_shadow_request, aux_shadow_request;
  logic                   main_single_shot_ctl, aux_single_shot_ctl;
  logic [dtb_pkg::DW-1:0] aux_compare_value, aux_compare_shadow_value;
  logic [dtb_pkg::DW-1:0] main_period, main_period_shadow;
  logic [dtb_pkg::DW-1:0] aux_period, aux_period_shadow;
  logic [dtb_pkg::PW-1:0] main_pre_cnt, aux_pre_cnt;
  logic                   main_tick, aux_tick, main_end, aux_end;
  logic                   main_st, aux_st, cmd_wr, ctrl_wr;
  logic                   main_run_set_cmd, main_run_clear_cmd;
  logic                   aux_run_set_cmd, aux_run_clear_cmd;
  logic                   main_str, main_std, aux_str, aux_std;
  logic [dtb_pkg::DW-1:0] ctrl_view, next_rdata;

  assign cmd_wr             = dtb_hit(reg_addr, dtb_pkg::CMD_OFS, reg_wr);
  assign ctrl_wr            = dtb_hit(reg_addr, dtb_pkg::CTRL_OFS, reg_wr);
  assign main_run_set_cmd   = cmd_wr && reg_wdata[dtb_pkg::MAIN_SET_BIT];
  assign main_run_clear_cmd = cmd_wr && reg_wdata[dtb_pkg::MAIN_CLR_BIT];
  assign aux_run_set_cmd    = cmd_wr && reg_wdata[dtb_pkg::AUX_SET_BIT];
  assign aux_run_clear_cmd  = cmd_wr && reg_wdata[dtb_pkg::AUX_CLR_BIT];
  assign main_str           = cmd_wr && reg_wdata[dtb_pkg::MAIN_STR_BIT];
  assign main_std           = cmd_wr && reg_wdata[dtb_pkg::MAIN_STD_BIT];
  assign aux_str            = cmd_wr && reg_wdata[dtb_pkg::AUX_STR_BIT];
  assign aux_std            = cmd_wr && reg_wdata[dtb_pkg::AUX_STD_BIT];

  // Count enables: 2^sel, times 256 when prescale is on
  assign main_tick = main_run_flag &&
    ((main_pre_cnt & dtb_div_mask(main_cfg)) ==
     dtb_div_mask(main_cfg));
  assign aux_tick = aux_run_flag &&
    ((aux_pre_cnt & dtb_div_mask(aux_cfg)) ==
     dtb_div_mask(aux_cfg));

  // Period end: wrap after period match, or bottom turn in center mode
  assign main_end = main_tick && (main_alignment_mode ?
    (main_count_direction && (main_count == dtb_pkg::ZERO16)) :
    (main_count == main_period));
  assign aux_end = aux_tick && (aux_count == aux_period);

  assign main_st = main_shadow_request && (main_end || !main_run_flag);
  assign aux_st  = aux_shadow_request && (aux_end || !aux_run_flag);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_pre_cnt <= dtb_pkg::PRE_ZERO;
      aux_pre_cnt  <= dtb_pkg::PRE_ZERO;
    end else begin
      main_pre_cnt <= main_run_flag ? main_pre_cnt + dtb_pkg::PRE_ONE :
                                      dtb_pkg::PRE_ZERO;
      aux_pre_cnt  <= aux_run_flag ? aux_pre_cnt + dtb_pkg::PRE_ONE :
                                     dtb_pkg::PRE_ZERO;
    end
  end

  // Clock config frozen while running so a live divider never glitches
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_cfg            <= dtb_pkg::CFG_RST;
      aux_cfg             <= dtb_pkg::CFG_RST;
      main_alignment_mode <= 1'b0;
    end else if (ctrl_wr) begin
      main_alignment_mode <= reg_wdata[dtb_pkg::MAIN_CTM_BIT];
      if (!main_run_flag) begin
        main_cfg.sel <= reg_wdata[dtb_pkg::MAIN_SEL_LSB +: 3];
        main_cfg.pre <= reg_wdata[dtb_pkg::MAIN_PRE_BIT];
      end
      if (!aux_run_flag) begin
        aux_cfg.sel <= reg_wdata[dtb_pkg::AUX_SEL_LSB +: 3];
        aux_cfg.pre <= reg_wdata[dtb_pkg::AUX_PRE_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_single_shot_ctl <= 1'b0;
      aux_single_shot_ctl  <= 1'b0;
    end else if (dtb_hit(reg_addr, dtb_pkg::SSHOT_OFS, reg_wr)) begin
      main_single_shot_ctl <= reg_wdata[dtb_pkg::MAIN_SS_BIT];
      aux_single_shot_ctl  <= reg_wdata[dtb_pkg::AUX_SS_BIT];
    end
  end

  // Any mix of set and clear sources leaves the flag alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_run_flag <= 1'b0;
    end else if (main_run_set_cmd &&
                 !(main_run_clear_cmd ||
                   (main_end && main_single_shot_ctl))) begin
      main_run_flag <= 1'b1;
    end else if (!main_run_set_cmd &&
                 (main_run_clear_cmd ||
                  (main_end && main_single_shot_ctl))) begin
      main_run_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_run_flag <= 1'b0;
    end else if (aux_run_set_cmd &&
                 !(aux_run_clear_cmd ||
                   (aux_end && aux_single_shot_ctl))) begin
      aux_run_flag <= 1'b1;
    end else if (!aux_run_set_cmd &&
                 (aux_run_clear_cmd ||
                  (aux_end && aux_single_shot_ctl))) begin
      aux_run_flag <= 1'b0;
    end
  end

  // A new request in the transfer cycle wins over the automatic clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_shadow_request <= 1'b0;
      aux_shadow_request  <= 1'b0;
    end else begin
      if (main_str) begin
        main_shadow_request <= 1'b1;
      end else if (main_st || main_std) begin
        main_shadow_request <= 1'b0;
      end
      if (aux_str) begin
        aux_shadow_request <= 1'b1;
      end else if (aux_st || aux_std) begin
        aux_shadow_request <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_compare_shadow_value <= dtb_pkg::ZERO16;
      main_period_shadow       <= dtb_pkg::ZERO16;
      aux_period_shadow        <= dtb_pkg::ZERO16;
    end else begin
      if (dtb_hit(reg_addr, dtb_pkg::CMP_SHD_OFS, reg_wr)) begin
        aux_compare_shadow_value <= reg_wdata;
      end
      if (dtb_hit(reg_addr, dtb_pkg::MPER_OFS, reg_wr)) begin
        main_period_shadow <= reg_wdata;
      end
      if (dtb_hit(reg_addr, dtb_pkg::APER_OFS, reg_wr)) begin
        aux_period_shadow <= reg_wdata;
      end
    end
  end

  // Active values have no software write path at all
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_compare_value <= dtb_pkg::ZERO16;
      aux_period        <= dtb_pkg::ZERO16;
      main_period       <= dtb_pkg::ZERO16;
    end else begin
      if (aux_st) begin
        aux_compare_value <= aux_compare_shadow_value;
        aux_period        <= aux_period_shadow;
      end
      if (main_st) begin
        main_period <= main_period_shadow;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_count           <= dtb_pkg::ZERO16;
      main_count_direction <= 1'b0;
    end else if (!main_alignment_mode) begin
      main_count_direction <= 1'b0;
      if (main_tick) begin
        main_count <= (main_count == main_period) ? dtb_pkg::ZERO16 :
                      main_count + dtb_pkg::ONE16;
      end
    end else if (main_tick) begin
      if (main_count_direction) begin
        if (main_count == dtb_pkg::ZERO16) begin
          main_count_direction <= 1'b0;
          main_count           <= main_count + dtb_pkg::ONE16;
        end else begin
          main_count <= main_count - dtb_pkg::ONE16;
        end
      end else if (main_count >= main_period) begin
        main_count_direction <= 1'b1;
        main_count           <= main_count - dtb_pkg::ONE16;
      end else begin
        main_count <= main_count + dtb_pkg::ONE16;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_count <= dtb_pkg::ZERO16;
    end else if (aux_tick) begin
      aux_count <= aux_end ? dtb_pkg::ZERO16 :
                   aux_count + dtb_pkg::ONE16;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_compare_match         <= 1'b0;
      aux_shadow_transfer_pulse <= 1'b0;
    end else begin
      aux_compare_match         <= (aux_count == aux_compare_value);
      aux_shadow_transfer_pulse <= aux_st;
    end
  end

  always_comb begin
    ctrl_view = dtb_pkg::ZERO16;
    ctrl_view[dtb_pkg::MAIN_SEL_LSB +: 3] = main_cfg.sel;
    ctrl_view[dtb_pkg::MAIN_PRE_BIT]      = main_cfg.pre;
    ctrl_view[dtb_pkg::MAIN_RUN_BIT]      = main_run_flag;
    ctrl_view[dtb_pkg::MAIN_REQ_BIT]      = main_shadow_request;
    ctrl_view[dtb_pkg::MAIN_DIR_BIT]      = main_count_direction;
    ctrl_view[dtb_pkg::MAIN_CTM_BIT]      = main_alignment_mode;
    ctrl_view[dtb_pkg::AUX_SEL_LSB +: 3]  = aux_cfg.sel;
    ctrl_view[dtb_pkg::AUX_PRE_BIT]       = aux_cfg.pre;
    ctrl_view[dtb_pkg::AUX_RUN_BIT]       = aux_run_flag;
    ctrl_view[dtb_pkg::AUX_REQ_BIT]       = aux_shadow_request;
  end

  always_comb begin
    next_rdata = dtb_pkg::ZERO16;
    unique case (reg_addr)
      dtb_pkg::CTRL_OFS:    next_rdata = ctrl_view;
      dtb_pkg::CMP_ACT_OFS: next_rdata = aux_compare_value;
      dtb_pkg::CMP_SHD_OFS: next_rdata = aux_compare_shadow_value;
      dtb_pkg::SSHOT_OFS: begin
        next_rdata[dtb_pkg::MAIN_SS_BIT] = main_single_shot_ctl;
        next_rdata[dtb_pkg::AUX_SS_BIT]  = aux_single_shot_ctl;
      end
      dtb_pkg::MPER_OFS:    next_rdata = main_period_shadow;
      dtb_pkg::APER_OFS:    next_rdata = aux_period_shadow;
      dtb_pkg::MCNT_OFS:    next_rdata = main_count;
      dtb_pkg::ACNT_OFS:    next_rdata = aux_count;
      default:              next_rdata = dtb_pkg::ZERO16;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= dtb_pkg::ZERO16;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : dtb_pkg::ZERO16;
    end
  end

  sequence s_edge_mode;
    !main_alignment_mode ##1 !main_alignment_mode;
  endsequence
  sequence s_div2_run;
    main_run_flag && main_tick && (main_cfg == 4'h1) ##1 main_run_flag;
  endsequence

  property p_cmp_load;
    @(posedge clk) disable iff (sys_rst)
      aux_st |=> aux_compare_value == $past(aux_compare_shadow_value);
  endproperty
  a_cmp_load: assert property (p_cmp_load)
    else $error("active compare not loaded on transfer");

  property p_cmp_hold;
    @(posedge clk) disable iff (sys_rst)
      !aux_st |=> $stable(aux_compare_value);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold)
    else $error("active compare changed without transfer");

  property p_main_set;
    @(posedge clk) disable iff (sys_rst)
      main_run_set_cmd && !main_run_clear_cmd && !main_end |=> main_run_flag;
  endproperty
  a_main_set: assert property (p_main_set)
    else $error("main run set command ignored");

  property p_aux_both;
    @(posedge clk) disable iff (sys_rst)
      aux_run_set_cmd && aux_run_clear_cmd |=> $stable(aux_run_flag);
  endproperty
  a_aux_both: assert property (p_aux_both)
    else $error("aux run flag changed on concurrent set and clear");

  property p_aux_stop;
    @(posedge clk) disable iff (sys_rst)
      !aux_run_flag |=> $stable(aux_count);
  endproperty
  a_aux_stop: assert property (p_aux_stop)
    else $error("aux counter moved while stopped");

  property p_cfg_lock;
    @(posedge clk) disable iff (sys_rst)
      main_run_flag |=> $stable(main_cfg);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock)
    else $error("main clock config changed while running");

  property p_edge_dir;
    @(posedge clk) disable iff (sys_rst)
      s_edge_mode |-> !main_count_direction;
  endproperty
  a_edge_dir: assert property (p_edge_dir)
    else $error("direction shows down in edge-aligned mode");

  property p_req_clr;
    @(posedge clk) disable iff (sys_rst)
      aux_st && !aux_str |=>
        !aux_shadow_request && aux_shadow_transfer_pulse;
  endproperty
  a_req_clr: assert property (p_req_clr)
    else $error("aux request not cleared by transfer");

  property p_stopped_st;
    @(posedge clk) disable iff (sys_rst)
      aux_shadow_request && !aux_run_flag && !aux_str |=>
        !aux_shadow_request && aux_shadow_transfer_pulse;
  endproperty
  a_stopped_st: assert property (p_stopped_st)
    else $error("no transfer while aux stopped");

  property p_div2;
    @(posedge clk) disable iff (sys_rst)
      s_div2_run |-> !main_tick ##1 (main_tick || !main_run_flag);
  endproperty
  a_div2: assert property (p_div2)
    else $error("divide-by-two tick spacing wrong");

endmodule
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                    clk;
  logic                    sys_rst;
  logic [dtb_pkg::AW-1:0]  reg_addr;
  logic [dtb_pkg::DW-1:0]  reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [dtb_pkg::DW-1:0]  reg_rdata;
  logic [dtb_pkg::DW-1:0]  main_count;
  logic [dtb_pkg::DW-1:0]  aux_count;
  logic                    aux_compare_match;
  logic                    aux_shadow_transfer_pulse;
  logic [15:0]             prev_aux;
  logic [15:0]             cmp_exp;
  logic [15:0]             d;
  logic                    match_on;
  int                      num_errors;
  int                      cmp_count;
  int                      cyc;
  int                      pulses;

  dtb_timer_ctrl u_dtb_timer_ctrl (
    .clk                       (clk),
    .sys_rst                   (sys_rst),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .main_count                (main_count),
    .aux_count                 (aux_count),
    .aux_compare_match         (aux_compare_match),
    .aux_shadow_transfer_pulse (aux_shadow_transfer_pulse)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rchk(input string n, input logic [15:0] a,
                      input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(n, v, e);
  endtask

  task automatic wait_cnt(input bit aux, input logic [15:0] v);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if ((aux ? aux_count : main_count) === v) break;
    end
    if (i == 3000) begin
      num_errors++;
      $display("ERROR count wait expected %h seen %h", v,
               (aux ? aux_count : main_count));
    end
  endtask

  // Cycles between two successive changes of the main count
  task automatic gap(output int n);
    logic [15:0] c;
    int          i;
    #1;
    c = main_count;
    for (i = 0; i < 1000 && main_count === c; i++) @(posedge clk) #1;
    c = main_count;
    for (n = 0; n < 1000 && main_count === c; n++) @(posedge clk) #1;
  endtask

  always @(negedge clk) begin
    cyc++;
    if (!sys_rst && aux_shadow_transfer_pulse === 1'b1) pulses++;
    if (match_on) begin
      chk("match", 16'(aux_compare_match), 16'(prev_aux == cmp_exp));
    end
    prev_aux = aux_count;
    if (cyc == 30000) begin
      num_errors++;
      $display("ERROR timeout expected %0d seen %0d", 0, cyc);
      wrap_up;
    end
  end

  task automatic t_aux;
    wr(dtb_pkg::APER_OFS, 16'h0005);
    wr(dtb_pkg::CMP_SHD_OFS, 16'h0003);
    wr(dtb_pkg::CMP_ACT_OFS, 16'hFFFF);
    rchk("act", dtb_pkg::CMP_ACT_OFS, 16'h0000);
    wr(dtb_pkg::CMD_OFS, 16'h4000);
    repeat (3) @(posedge clk);
    rchk("act", dtb_pkg::CMP_ACT_OFS, 16'h0003);
    rchk("shd", dtb_pkg::CMP_SHD_OFS, 16'h0003);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0000);
    chk("pulses", 16'(pulses), 16'h0001);
    cmp_exp = 16'h0003;
    wr(dtb_pkg::CMD_OFS, 16'h0200);
    match_on <= 1'b1;
    repeat (40) @(posedge clk);
    match_on <= 1'b0;
    wr(dtb_pkg::CMD_OFS, 16'h0100);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0000);
    d = aux_count;
    repeat (5) @(posedge clk);
    #1 chk("aux stop", aux_count, d);
    $display("Test aux compare finished");
  endtask

  task automatic t_pend;
    int i;
    wr(dtb_pkg::CTRL_OFS, 16'h0700);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0700);
    wr(dtb_pkg::CMD_OFS, 16'h0200);
    wr(dtb_pkg::CTRL_OFS, 16'h0000);
    wr(dtb_pkg::CMP_SHD_OFS, 16'h0002);
    wr(dtb_pkg::CMD_OFS, 16'h4000);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h3700);
    rchk("act", dtb_pkg::CMP_ACT_OFS, 16'h0003);
    for (i = 0; i < 2000 && aux_shadow_transfer_pulse !== 1'b1; i++) begin
      @(posedge clk) #1;
    end
    chk("aux wrap", aux_count, 16'h0000);
    rchk("act", dtb_pkg::CMP_ACT_OFS, 16'h0002);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h1700);
    wr(dtb_pkg::CMD_OFS, 16'h4000);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h3700);
    wr(dtb_pkg::CMD_OFS, 16'h8000);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h1700);
    wr(dtb_pkg::CMD_OFS, 16'h0100);
    wr(dtb_pkg::CTRL_OFS, 16'h0000);
    wr(dtb_pkg::SSHOT_OFS, 16'h0002);
    wr(dtb_pkg::CMD_OFS, 16'h0200);
    wait_cnt(1'b1, 16'h0005);
    repeat (6) @(posedge clk);
    #1 chk("single shot", aux_count, 16'h0000);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0000);
    $display("Test pending and single shot finished");
  endtask

  task automatic t_run;
    wr(dtb_pkg::MPER_OFS, 16'h0008);
    wr(dtb_pkg::CMD_OFS, 16'h0040);
    wr(dtb_pkg::CMD_OFS, 16'h0303);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0000);
    wr(dtb_pkg::CMD_OFS, 16'h0000);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0000);
    wr(dtb_pkg::CMD_OFS, 16'h0002);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0010);
    wr(dtb_pkg::CMD_OFS, 16'h0003);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0010);
    d = main_count;
    repeat (3) @(posedge clk);
    #1 chk("main counts", 16'(main_count !== d), 16'h0001);
    wr(dtb_pkg::CMD_OFS, 16'h0001);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0000);
    $display("Test main run finished");
  endtask

  task automatic t_div;
    logic [3:0] cfg [5] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'h8};
    int         n;
    foreach (cfg[k]) begin
      wr(dtb_pkg::CTRL_OFS, {12'h000, cfg[k]});
      wr(dtb_pkg::CMD_OFS, 16'h0002);
      gap(n);
      chk("gap", 16'(n), 16'(1 << (cfg[k][2:0] + 8 * cfg[k][3])));
      wr(dtb_pkg::CTRL_OFS, {12'h000, cfg[k] ^ 4'h9});
      gap(n);
      chk("gap held", 16'(n), 16'(1 << (cfg[k][2:0] + 8 * cfg[k][3])));
      wr(dtb_pkg::CMD_OFS, 16'h0001);
    end
    $display("Test divider finished");
  endtask

  task automatic t_mode;
    wr(dtb_pkg::CTRL_OFS, 16'h0080);
    wr(dtb_pkg::CMD_OFS, 16'h0002);
    wait_cnt(1'b0, 16'h0008);
    @(posedge clk);
    #1 chk("center", main_count, 16'h0007);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h00D0);
    wait_cnt(1'b0, 16'h0000);
    wait_cnt(1'b0, 16'h0003);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0090);
    wr(dtb_pkg::CTRL_OFS, 16'h0000);
    wait_cnt(1'b0, 16'h0008);
    @(posedge clk);
    #1 chk("edge", main_count, 16'h0000);
    wr(dtb_pkg::SSHOT_OFS, 16'h0001);
    wait_cnt(1'b0, 16'h0008);
    repeat (3) @(posedge clk);
    #1 chk("main single shot", main_count, 16'h0000);
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0000);
    wr(dtb_pkg::CMD_OFS, 16'h0001);
    $display("Test mode finished");
  endtask

  initial begin
    sys_rst   = 1'b1;
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    match_on  = 1'b0;
    cmp_exp   = '0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rchk("ctrl", dtb_pkg::CTRL_OFS, 16'h0000);
    rchk("act", dtb_pkg::CMP_ACT_OFS, 16'h0000);
    rchk("unmapped", 16'hE8B0, 16'h0000);
    $display("Test reset finished");
    t_aux;
    t_pend;
    t_run;
    t_div;
    t_mode;
    wrap_up;
  end
endmodule
`default_nettype wire
